// ===== core/tmr_pkg.sv
// Package for the timer B / timer C down-counter block.
// Assumes a single 125 MHz clock domain and an 8-bit register port.
package tmr_pkg;
  localparam logic [7:0] TMR_B_CTRL_ADDR = 8'h19;
  localparam logic [7:0] TMR_B_RLD_HI_ADDR = 8'h1a;
  localparam logic [7:0] TMR_B_RLD_LO_ADDR = 8'h1b;
  localparam logic [7:0] TMR_B_CNT_HI_ADDR = 8'h1c;
  localparam logic [7:0] TMR_B_CNT_LO_ADDR = 8'h1d;
  localparam logic [7:0] TMR_C_CTRL_ADDR = 8'h1e;
  localparam logic [7:0] TMR_C_RLD_HI_ADDR = 8'h1f;
  localparam logic [7:0] TMR_C_RLD_LO_ADDR = 8'h20;
  localparam logic [7:0] TMR_C_CNT_HI_ADDR = 8'h21;
  localparam logic [7:0] TMR_C_CNT_LO_ADDR = 8'h22;
  localparam logic [7:0] TMR_FLAG_ADDR = 8'h24;
  localparam int TMR_HALT_BIT = 7;
  localparam int TMR_SRC_HI = 5;
  localparam int TMR_SRC_LO = 4;
  localparam int TMR_AUTO_BIT = 3;
  localparam int TMR_CLK_HI = 1;
  localparam int TMR_CLK_LO = 0;
  localparam logic [7:0] TMR_CTRL_MASK = 8'hbb;
  localparam logic [7:0] TMR_CTRL_RST = 8'h00;
  localparam logic [7:0] TMR_BYTE_RST = 8'h00;
  localparam logic [15:0] TMR_CNT_RST = 16'h0000;
  localparam logic [1:0] TMR_SRC_NONE = 2'h0;
  localparam logic [1:0] TMR_SRC_TX_END = 2'h1;
  localparam logic [1:0] TMR_SRC_TRIM = 2'h2;
  localparam logic [1:0] TMR_SRC_TRIM_UF = 2'h3;
  localparam logic [1:0] TMR_CLK_FAST = 2'h0;
  localparam logic [1:0] TMR_CLK_SLOW = 2'h1;
  localparam logic [1:0] TMR_CLK_UF0 = 2'h2;
  localparam logic [1:0] TMR_CLK_UF1 = 2'h3;
  localparam int TMR_NUM = 2;
endpackage

// ===== core/tmr_sync.sv
// Two-flop synchroniser for pin-level inputs.
// Assumes the input is asynchronous to ref_clk.
`timescale 1ns/1ps
module tmr_sync
  import tmr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_r;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_r <= 1'b0;
      sync_out <= 1'b0;
    end else if (clk_en) begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // tmr_sync

// ===== core/tmr_counter.sv
// One 16-bit reloadable down-counter with start, halt and trim control.
// Assumes start and event inputs are single-cycle pulses on ref_clk; tick may be held high to count every cycle.
`timescale 1ns/1ps
module tmr_counter
  import tmr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [7:0] ctrl,
  input wire logic [15:0] reload,
  input wire logic tick,
  input wire logic tx_end,
  input wire logic rx_four,
  input wire logic trim_edge,
  output logic [15:0] count,
  output logic running,
  output logic underflow
);
  logic [15:0] count_nxt;
  logic running_nxt;
  logic [1:0] src;
  logic is_trim;
  logic start_ev;
  logic stop_ev;
  logic at_zero;
  assign src = ctrl[TMR_SRC_HI:TMR_SRC_LO];
  assign is_trim = src[1];
  // Trim mode toggles run state on each rising edge of the slow oscillator
  assign start_ev = ((src == TMR_SRC_TX_END) & tx_end) | (is_trim & trim_edge & ~running);
  assign stop_ev = (ctrl[TMR_HALT_BIT] & ~is_trim & rx_four) | (is_trim & trim_edge & running);
  assign at_zero = (count == 16'h0000);
  always_comb begin
    count_nxt = count;
    running_nxt = running;
    underflow = 1'b0;
    if (start_ev) begin
      count_nxt = reload;
      running_nxt = 1'b1;
    end else if (stop_ev) begin
      running_nxt = 1'b0;
    end else if (running && tick) begin
      if (at_zero) begin
        underflow = 1'b1;
        // Trim without underflow holds at zero rather than wrapping
        if (src == TMR_SRC_TRIM) begin
          underflow = 1'b0;
        end else if (ctrl[TMR_AUTO_BIT]) begin
          count_nxt = reload;
        end else begin
          running_nxt = 1'b0;
        end
      end else begin
        count_nxt = count - 16'h0001;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count <= TMR_CNT_RST;
      running <= 1'b0;
    end else if (clk_en) begin
      count <= count_nxt;
      running <= running_nxt;
    end
  end
endmodule // tmr_counter

// ===== core/tmr_top.sv
// Register block and two down-counters (timer B, timer C).
// Assumes a same-clock register master; slow oscillator and slow tick come from pins.
`timescale 1ns/1ps
// Overview of operation
// - Halt bit stops timer after four received bits
// - Halt bit ignored in trim modes
// - Source 00 none, 01 start at tx end
// - Sources 10/11 trim, edge start/stop
// - Auto reload restarts from reload at zero, except in source 10
// - Without auto reload stop at zero, except in source 10 (holds at zero)
// - Underflow sets sticky timer flag
// - Timer B clock select fast/slow/uf0/uf1
// - Timer C clock select fast/slow/uf0/uf1
// - Start loads counter from reload bytes
// - Reload writes affect the next start or auto reload
// - Live count readable as two bytes
// - Timer B reload bytes at 1a, 1b
// - Timer C control at 1e with fields
// - Timer C reload high at 1f
// - Timer B control at 19
// - Timer C reload low 20, counts 21/22
module tmr_top
  import tmr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic slow_tick_pin,
  input wire logic slow_oscillator,
  input wire logic tx_end,
  input wire logic rx_four_bits,
  input wire logic timer_0_underflow,
  input wire logic timer_a_underflow_flag,
  output logic timer_b_underflow_flag,
  output logic timer_c_underflow_flag,
  output logic timer_b_running,
  output logic timer_c_running
);
  logic [7:0] ctrl_r [TMR_NUM];
  logic [7:0] rld_hi_r [TMR_NUM];
  logic [7:0] rld_lo_r [TMR_NUM];
  logic [15:0] cnt [TMR_NUM];
  logic run [TMR_NUM];
  logic uf [TMR_NUM];
  logic [TMR_NUM-1:0] flag_r;
  logic [TMR_NUM-1:0] flag_nxt;
  logic [7:0] ctrl_addr [TMR_NUM];
  logic [7:0] hi_addr [TMR_NUM];
  logic [7:0] lo_addr [TMR_NUM];
  logic [7:0] chi_addr [TMR_NUM];
  logic [7:0] clo_addr [TMR_NUM];
  logic slow_lvl;
  logic slow_lvl_d_r;
  logic slow_tick;
  logic osc_lvl;
  logic osc_d_r;
  logic osc_rise;
  logic [7:0] rdata_nxt;
  logic flag_sel;
  logic [TMR_NUM-1:0] run_r;
  assign ctrl_addr[0] = TMR_B_CTRL_ADDR;
  assign ctrl_addr[1] = TMR_C_CTRL_ADDR;
  assign hi_addr[0] = TMR_B_RLD_HI_ADDR;
  assign hi_addr[1] = TMR_C_RLD_HI_ADDR;
  assign lo_addr[0] = TMR_B_RLD_LO_ADDR;
  assign lo_addr[1] = TMR_C_RLD_LO_ADDR;
  assign chi_addr[0] = TMR_B_CNT_HI_ADDR;
  assign chi_addr[1] = TMR_C_CNT_HI_ADDR;
  assign clo_addr[0] = TMR_B_CNT_LO_ADDR;
  assign clo_addr[1] = TMR_C_CNT_LO_ADDR;
  tmr_sync u_sync_slow (
    .ref_clk(ref_clk),
    .srst(srst),
    .clk_en(clk_en),
    .async_in(slow_tick_pin),
    .sync_out(slow_lvl)
  );
  tmr_sync u_sync_osc (
    .ref_clk(ref_clk),
    .srst(srst),
    .clk_en(clk_en),
    .async_in(slow_oscillator),
    .sync_out(osc_lvl)
  );
  assign slow_tick = slow_lvl & ~slow_lvl_d_r;
  assign osc_rise = osc_lvl & ~osc_d_r;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      slow_lvl_d_r <= 1'b0;
      osc_d_r <= 1'b0;
    end else if (clk_en) begin
      slow_lvl_d_r <= slow_lvl;
      osc_d_r <= osc_lvl;
    end
  end
  // The 13.56 MHz tick is taken as every ref_clk cycle; the real rate is set upstream
  genvar i;
  generate
    for (i = 0; i < TMR_NUM; i++) begin : g_tmr
      logic tick;
      logic wr_ctrl;
      logic wr_hi;
      logic wr_lo;
      assign wr_ctrl = reg_wr & (reg_addr == ctrl_addr[i]);
      assign wr_hi = reg_wr & (reg_addr == hi_addr[i]);
      assign wr_lo = reg_wr & (reg_addr == lo_addr[i]);
      always_comb begin
        case (ctrl_r[i][TMR_CLK_HI:TMR_CLK_LO])
          TMR_CLK_FAST: tick = 1'b1;
          TMR_CLK_SLOW: tick = slow_tick;
          TMR_CLK_UF0: tick = timer_0_underflow;
          TMR_CLK_UF1: tick = timer_a_underflow_flag;
          default: tick = 1'b0;
        endcase
      end
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          ctrl_r[i] <= TMR_CTRL_RST;
          rld_hi_r[i] <= TMR_BYTE_RST;
          rld_lo_r[i] <= TMR_BYTE_RST;
        end else if (clk_en) begin
          if (wr_ctrl) ctrl_r[i] <= reg_wdata & TMR_CTRL_MASK;
          if (wr_hi) rld_hi_r[i] <= reg_wdata;
          if (wr_lo) rld_lo_r[i] <= reg_wdata;
        end
      end
      tmr_counter u_cnt (
        .ref_clk(ref_clk),
        .srst(srst),
        .clk_en(clk_en),
        .ctrl(ctrl_r[i]),
        .reload({rld_hi_r[i], rld_lo_r[i]}),
        .tick(tick),
        .tx_end(tx_end),
        .rx_four(rx_four_bits),
        .trim_edge(osc_rise),
        .count(cnt[i]),
        .running(run[i]),
        .underflow(uf[i])
      );
      // Set wins over a software clear in the same cycle
      assign flag_nxt[i] = uf[i] |
        (flag_r[i] & ~(reg_wr & flag_sel & reg_wdata[i]));
    end
  endgenerate
  assign flag_sel = (reg_addr == TMR_FLAG_ADDR);
  always_comb begin
    rdata_nxt = 8'h00;
    for (int k = 0; k < TMR_NUM; k++) begin
      if (reg_addr == ctrl_addr[k]) rdata_nxt = ctrl_r[k];
      if (reg_addr == hi_addr[k]) rdata_nxt = rld_hi_r[k];
      if (reg_addr == lo_addr[k]) rdata_nxt = rld_lo_r[k];
      if (reg_addr == chi_addr[k]) rdata_nxt = cnt[k][15:8];
      if (reg_addr == clo_addr[k]) rdata_nxt = cnt[k][7:0];
    end
    if (flag_sel) rdata_nxt = {6'h00, flag_r};
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
      flag_r <= '0;
      run_r <= '0;
    end else if (clk_en) begin
      // Unmapped or idle reads return zero
      reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
      flag_r <= flag_nxt;
      run_r <= {run[1], run[0]};
    end
  end
  assign timer_b_underflow_flag = flag_r[0];
  assign timer_c_underflow_flag = flag_r[1];
  assign timer_b_running = run_r[0];
  assign timer_c_running = run_r[1];

  chk_flag_set: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && uf[0] |=> flag_r[0]) else $error("flag b not set on underflow");
  chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (srst)
    (ctrl_r[0][6] == 1'b0) && (ctrl_r[0][2] == 1'b0) && (ctrl_r[1][6] == 1'b0) &&
    (ctrl_r[1][2] == 1'b0))
    else $error("reserved bit set");
  chk_halt_rx: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && run[0] && ctrl_r[0][7] && !ctrl_r[0][5] && rx_four_bits && !tx_end
    |=> !run[0]) else $error("halt on receive missed");
  chk_trim_no_halt: assert property (@(posedge ref_clk) disable iff (srst)
    // An underflow without auto reload may stop the timer in the same cycle
    clk_en && run[1] && ctrl_r[1][5] && rx_four_bits && !osc_rise && !uf[1] |=> run[1])
    else $error("halt acted in trim mode");
  chk_tx_start: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && ctrl_r[0][5:4] == TMR_SRC_TX_END && tx_end |=> run[0] &&
    cnt[0] == $past({rld_hi_r[0], rld_lo_r[0]})) else $error("tx end start failed");
  chk_no_auto: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && uf[1] && !ctrl_r[1][3] && !tx_end && !osc_rise |=> !run[1])
    else $error("timer kept running");
  chk_auto_reload: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && uf[0] && ctrl_r[0][3] |=> run[0] &&
    cnt[0] == $past({rld_hi_r[0], rld_lo_r[0]})) else $error("auto reload failed");
  chk_fast_dec: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && run[0] && ctrl_r[0][1:0] == TMR_CLK_FAST && cnt[0] != 16'h0000 &&
    !tx_end && !rx_four_bits && !osc_rise |=> cnt[0] == $past(cnt[0]) - 16'h0001)
    else $error("count did not decrement");
  cov_uf_b: cover property (@(posedge ref_clk) uf[0]);
  cov_uf_c: cover property (@(posedge ref_clk) uf[1]);
  cov_halt: cover property (@(posedge ref_clk) run[0] ##1 !run[0]);
endmodule // tmr_top

// ===== verification/tmr_top_tb_top.sv
// Self-checking bench for the timer B / timer C block, with an integer model of both counters.
// Assumes the register port and event pulses of tmr_top, all on ref_clk.
`timescale 1ns/1ps
module tmr_top_tb_top;
  import tmr_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic slow_osc = 1'b0;
  logic slow_pin = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [1:0] flag_o;
  logic [1:0] run_o;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int mc;
  int mrl;
  bit mrun;
  bit mauto;
  bit [1:0] mflag = 2'h0;
  bit [31:0] lf = 32'h1046;

  always #4 ref_clk = ~ref_clk;

  tmr_top dut_u (.ref_clk(ref_clk), .srst(srst), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .slow_tick_pin(slow_pin), .slow_oscillator(slow_osc), .tx_end(ev[0]), .rx_four_bits(ev[1]),
    .timer_0_underflow(ev[2]), .timer_a_underflow_flag(ev[3]),
    .timer_b_underflow_flag(flag_o[0]), .timer_c_underflow_flag(flag_o[1]),
    .timer_b_running(run_o[0]), .timer_c_running(run_o[1]));

  // Cuts a hang short; the whole run needs a few hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  function automatic bit [31:0] nxt(input bit [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic pulse(input int i);
    @(posedge ref_clk);
    ev[i] <= 1'b1;
    @(posedge ref_clk);
    ev[i] <= 1'b0;
  endtask

  // One count tick from the selected underflow source, mirrored in the model
  task automatic tick(input int t);
    pulse(t ? 2 : 3);
    if (mrun) begin
      if (mc == 0) begin
        mflag[t] = 1'b1;
        if (mauto) mc = mrl;
        else mrun = 1'b0;
      end else begin
        mc--;
      end
    end
  endtask

  task automatic cmp(input int t);
    logic [7:0] a, h, l;
    // Counts are read only while no reception is under way
    a = t ? TMR_C_CNT_HI_ADDR : TMR_B_CNT_HI_ADDR;
    rd(a, h);
    rd(a + 8'h01, l);
    chk("count", mc[15:0], {h, l});
    chk("running", {15'h0, mrun}, {15'h0, run_o[t]});
    chk("flag", {15'h0, mflag[t]}, {15'h0, flag_o[t]});
  endtask

  task automatic run_timer(input int t);
    logic [7:0] a, ck, h;
    a = t ? TMR_C_CTRL_ADDR : TMR_B_CTRL_ADDR;
    ck = t ? {6'h0, TMR_CLK_UF0} : {6'h0, TMR_CLK_UF1};
    lf = nxt(lf);
    mrl = {lf[15:8], lf[7:0] | 8'h04};
    wr(a + 8'h01, mrl[15:8]);
    wr(a + 8'h02, mrl[7:0]);
    wr(a, 8'h90 | ck);
    mauto = 1'b0;
    pulse(0);
    mc = mrl;
    mrun = 1'b1;
    cmp(t);
    tick(t);
    tick(t);
    cmp(t);
    wr(a + 8'h01, 8'h00);
    wr(a + 8'h02, 8'h02);
    mrl = 2;
    cmp(t);
    pulse(1);
    mrun = 1'b0;
    tick(t);
    cmp(t);
    pulse(0);
    mc = mrl;
    mrun = 1'b1;
    repeat (3) tick(t);
    cmp(t);
    rd(TMR_FLAG_ADDR, h);
    chk("flags", {14'h0, mflag}, {8'h00, h});
    wr(TMR_FLAG_ADDR, 8'h01 << t);
    mflag[t] = 1'b0;
    wr(a, 8'h18 | ck);
    mauto = 1'b1;
    pulse(0);
    mc = mrl;
    mrun = 1'b1;
    repeat (4) tick(t);
    cmp(t);
    pulse(1);
    tick(t);
    cmp(t);
    // With the halt bit set the receive pulse stops the count where it stands, so a wrong start would show as a reload
    wr(a, 8'h80 | ck);
    pulse(1);
    mrun = 1'b0;
    pulse(0);
    tick(t);
    cmp(t);
    wr(a, 8'ha0 | ck);
    slow_osc <= 1'b1;
    repeat (6) @(posedge ref_clk);
    mc = mrl;
    mrun = 1'b1;
    mauto = 1'b0;
    pulse(1);
    tick(t);
    cmp(t);
    slow_osc <= 1'b0;
    repeat (6) @(posedge ref_clk);
    slow_osc <= 1'b1;
    repeat (6) @(posedge ref_clk);
    mrun = 1'b0;
    tick(t);
    cmp(t);
    slow_osc <= 1'b0;
    wr(a, 8'h00);
    $display("timer %0d test done", t);
  endtask

  initial begin
    logic [7:0] d;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    for (int a = 8'h19; a <= 8'h24; a++) begin
      rd(a[7:0], d);
      chk("reset value", 16'h0, {8'h00, d});
    end
    wr(8'h30, 8'hff);
    rd(8'h30, d);
    chk("unmapped", 16'h0, {8'h00, d});
    wr(TMR_B_CNT_LO_ADDR, 8'h55);
    rd(TMR_B_CNT_LO_ADDR, d);
    chk("count read only", 16'h0, {8'h00, d});
    wr(TMR_B_CTRL_ADDR, 8'hff);
    wr(TMR_C_CTRL_ADDR, 8'hff);
    rd(TMR_B_CTRL_ADDR, d);
    chk("control b", {8'h00, TMR_CTRL_MASK}, {8'h00, d});
    rd(TMR_C_CTRL_ADDR, d);
    chk("control c", {8'h00, TMR_CTRL_MASK}, {8'h00, d});
    wr(TMR_B_CTRL_ADDR, 8'h00);
    wr(TMR_C_CTRL_ADDR, 8'h00);
    $display("register map test done");
    run_timer(0);
    run_timer(1);
    wr(TMR_B_RLD_HI_ADDR, 8'h00);
    wr(TMR_B_RLD_LO_ADDR, 8'h10);
    wr(TMR_B_CTRL_ADDR, 8'h11);
    mauto = 1'b0;
    pulse(0);
    mc = 16;
    mrun = 1'b1;
    repeat (3) begin
      slow_pin <= 1'b1;
      repeat (4) @(posedge ref_clk);
      slow_pin <= 1'b0;
      repeat (4) @(posedge ref_clk);
      mc--;
    end
    cmp(0);
    wr(TMR_B_CTRL_ADDR, 8'h00);
    $display("slow clock test done");
    test_done();
  end
endmodule // tmr_top_tb_top
